// File: hw/dcs_pkg.sv
// shared constants, enums and carrier structs of the disk command sequencer
package dcs_pkg;
	// timing
	localparam int CLK_MHZ = 250;
	localparam int TMO_MS  = 200;
	localparam int TMO_CYC = TMO_MS * 1000 * CLK_MHZ;
	localparam int TMO_W   = 26;

	// widths and limits
	localparam int          AW       = 4;
	localparam int          DW       = 8;
	localparam int          TRK_W    = 10;
	localparam logic [7:0]  SECT_MAX = 8'h2f;

	// command offsets (write strobe)
	localparam logic [3:0] A_CYL_HI = 4'h0;
	localparam logic [3:0] A_SEEK   = 4'h1;
	localparam logic [3:0] A_RECAL  = 4'h2;
	localparam logic [3:0] A_READ   = 4'h3;
	localparam logic [3:0] A_WRITE  = 4'h4;
	localparam logic [3:0] A_CHECK  = 4'h5;
	localparam logic [3:0] A_ERRRST = 4'h6;

	// status offsets (read strobe)
	localparam logic [3:0] A_STATUS = 4'h0;
	localparam logic [3:0] A_ERR_LO = 4'h1;
	localparam logic [3:0] A_ERR_HI = 4'h2;
	localparam logic [3:0] A_TRK_LO = 4'h3;
	localparam logic [3:0] A_TRK_HI = 4'h4;
	localparam logic [3:0] A_SECT   = 4'h5;

	// status byte bit positions
	localparam int ST_BUSY = 0;
	localparam int ST_XACT = 1;
	localparam int ST_AVL  = 2;

	typedef enum logic [1:0] {XM_READ, XM_WRITE, XM_CHECK} xfer_mode_t;

	typedef enum logic [2:0] {
		S_IDLE, S_SEEK, S_RECAL, S_READ, S_WRITE, S_WR_CHK, S_CHECK
	} seq_st_t;

	// sticky error flags, error byte low holds bits 7:0
	typedef struct packed {
		logic restart;
		logic ram_par;
		logic missing;
		logic pos_tmo;
		logic servo_par;
		logic fault;
		logic crc;
		logic overrun;
		logic xfer_tmo;
		logic protect;
		logic xfer_fail;
		logic pos_err;
	} err_flags_t;

	// drive condition lines, levels
	typedef struct packed {
		logic available;
		logic protect;
		logic fault;
		logic servo_par;
		logic ram_par;
		logic restart;
	} drv_stat_t;

	// seek answer from the mechanism, one-cycle pulses
	typedef struct packed {
		logic done;
		logic err;
	} seek_rsp_t;

	// sector channel answer, one-cycle pulses
	typedef struct packed {
		logic done;
		logic miss;
		logic overrun;
		logic crc;
	} xfer_rsp_t;
endpackage

// File: hw/dcs_reset_sync.sv
// reset release synchroniser
module dcs_reset_sync (
	input  wire logic mclk_i,
	input  wire logic reset_n_i,
	output logic      rst_n_o
);
	logic [1:0] sync_q;

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_q <= 2'h0;
		end else begin
			sync_q <= {sync_q[0], 1'b1};
		end
	end

	assign rst_n_o = sync_q[1];
endmodule

// File: hw/dcs_timeout.sv
// watchdog: pulses after every CYC cycles of run, restarts when run drops
module dcs_timeout import dcs_pkg::*; #(
	parameter int CYC = TMO_CYC
) (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic run_i,
	output logic      expired_o
);
	typedef struct packed {
		logic [TMO_W-1:0] cnt;
		logic             hit;
	} tmr_state_t;

	tmr_state_t q, d;

	always_comb begin
		d = q;
		d.hit = 1'b0;
		if (!run_i) begin
			d.cnt = '0;
		end else if (q.cnt == TMO_W'(CYC - 1)) begin
			d.cnt = '0;
			d.hit = 1'b1;
		end else begin
			d.cnt = q.cnt + TMO_W'(1);
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign expired_o = q.hit;
endmodule

// File: hw/disk_command_sequencer.sv
// disk command interpreter: host commands, seek and sector sequencing, error flags
//Contract
//[RULE1] host issues only recalibrate while busy, transferring, positioning error or offline
//[RULE2] cylinder-high command puts data bits 1:0 into track bits 9:8
//[RULE3] seek command loads track bits 7:0 and starts a seek
//[RULE4] busy stays true during a seek and drops on a seek error
//[RULE5] host must recalibrate after any positioning error
//[RULE6] recalibrate clears all twelve error flags
//[RULE7] recalibrate returns heads to track zero, surface zero
//[RULE8] host recalibrates only when available and idle, or drive fault set; the code accepts recalibrate in any state
//[RULE9] read loads sector address and reads it; sectors 0 to 47 only
//[RULE10] transfer-active is true throughout read, write and write-verify
//[RULE11] sector not located: drop transfer-active, set missing flag
//[RULE12] overrun past sector length: drop transfer-active, set failure and overrun
//[RULE13] checksum fail on read or verify: drop transfer-active, set checksum and failure
//[RULE14] sector command over 200 ms: drop transfer-active, set failure and timeout
//[RULE15] write loads sector address and writes the whole buffer
//[RULE16] write-verify writes, then checks next revolution without buffer copy
//[RULE17] missing sector in either write-verify phase sets missing flag
//[RULE18] error reset clears protect, timeout, overrun, checksum, missing only
//[RULE19] buffer pointer returns to zero when a sector operation ends
//[RULE20] write on protected media sets the protect flag
//[RULE21] seek or recalibrate over 200 ms sets position timeout
//[RULE22] clean completion clears transfer-active or busy without errors
//[RULE23] sector above 47 sets missing flag, no transfer
module disk_command_sequencer import dcs_pkg::*; #(
	parameter int SEEK_TMO_CYC = TMO_CYC,
	parameter int XFER_TMO_CYC = TMO_CYC
) (
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          reset_n_i,
	// register port
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic [DW-1:0]      rdata_o,
	// drive conditions and answers
	input  wire drv_stat_t     drv_i,
	input  wire seek_rsp_t     seek_i,
	input  wire xfer_rsp_t     xfer_i,
	// seek channel
	output logic               seek_req_o,
	output logic               recal_o,
	output logic [TRK_W-1:0]   seek_track_o,
	// sector channel
	output logic               xfer_req_o,
	output xfer_mode_t         xfer_mode_o,
	output logic [DW-1:0]      xfer_sector_o,
	output logic               buf_ptr_clr_o,
	// status
	output logic               busy_o,
	output logic               xfer_active_o
);
	typedef struct packed {
		seq_st_t          st;
		logic             busy;
		logic             xact;
		logic [TRK_W-1:0] trk;
		logic [DW-1:0]    sect;
		err_flags_t       err;
		logic             seek_req;
		logic             recal;
		logic             xfer_req;
		xfer_mode_t       mode;
		logic             ptr_clr;
		logic [DW-1:0]    rdata;
	} seq_state_t;

	seq_state_t q, d;
	err_flags_t ev;
	logic       rst_n;
	logic       cmd_ok;
	logic       seek_tmo;
	logic       xfer_tmo;
	logic       in_seek;
	logic       in_xfer;

	dcs_reset_sync u_rst (
		.mclk_i    (mclk_i),
		.reset_n_i (reset_n_i),
		.rst_n_o   (rst_n)
	);

	assign in_seek = (q.st == S_SEEK) || (q.st == S_RECAL);
	assign in_xfer = q.xact;

	dcs_timeout #(.CYC(SEEK_TMO_CYC)) u_seek_tmo (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n),
		.run_i     (in_seek),
		.expired_o (seek_tmo)
	);

	dcs_timeout #(.CYC(XFER_TMO_CYC)) u_xfer_tmo (
		.mclk_i    (mclk_i),
		.rst_n_i   (rst_n),
		.run_i     (in_xfer),
		.expired_o (xfer_tmo)
	);

	// disk commands refused while busy, transferring, mispositioned or offline
	assign cmd_ok = drv_i.available && !q.busy && !q.xact && !q.err.pos_err; // [RULE1]

	always_comb begin
		d = q;
		ev = '0;
		d.seek_req = 1'b0;
		d.recal = 1'b0;
		d.xfer_req = 1'b0;
		d.ptr_clr = 1'b0;
		d.rdata = '0;

		// drive condition lines latch into sticky flags
		ev.fault = drv_i.fault;
		ev.servo_par = drv_i.servo_par;
		ev.ram_par = drv_i.ram_par;
		ev.restart = drv_i.restart;

		// mechanism answers
		unique case (q.st)
			S_SEEK, S_RECAL: begin
				if (seek_i.err || seek_tmo) begin
					d.busy = 1'b0; // [RULE4]
					d.st = S_IDLE;
					ev.pos_err = seek_i.err;
					ev.pos_tmo = seek_tmo; // [RULE21]
				end else if (seek_i.done) begin
					d.busy = 1'b0; // [RULE22]
					d.st = S_IDLE;
				end
			end
			S_READ, S_WRITE, S_WR_CHK, S_CHECK: begin
				if (xfer_tmo) begin
					ev.xfer_fail = 1'b1; // [RULE14]
					ev.xfer_tmo = 1'b1;
				end else if (xfer_i.miss) begin
					ev.missing = 1'b1; // [RULE11] [RULE17]
				end else if (xfer_i.overrun) begin
					ev.xfer_fail = 1'b1; // [RULE12]
					ev.overrun = 1'b1;
				end else if (xfer_i.crc && (q.st == S_READ || q.st == S_CHECK)) begin
					ev.crc = 1'b1; // [RULE13]
					ev.xfer_fail = 1'b1;
				end
				if (xfer_tmo || xfer_i.miss || xfer_i.overrun || ev.crc) begin
					d.xact = 1'b0;
					d.st = S_IDLE;
					d.ptr_clr = 1'b1; // [RULE19]
				end else if (xfer_i.done && q.st == S_WR_CHK) begin
					// second pass on the next revolution, checksum only
					d.st = S_CHECK; // [RULE16]
					d.xfer_req = 1'b1;
					d.mode = XM_CHECK;
				end else if (xfer_i.done) begin
					d.xact = 1'b0; // [RULE22]
					d.st = S_IDLE;
					d.ptr_clr = 1'b1; // [RULE19]
				end
			end
			default: begin
			end
		endcase

		// register reads
		if (rd_i) begin
			unique case (addr_i)
				A_STATUS: begin
					d.rdata[ST_BUSY] = q.busy;
					d.rdata[ST_XACT] = q.xact;
					d.rdata[ST_AVL] = drv_i.available;
				end
				A_ERR_LO: d.rdata = q.err[7:0];
				A_ERR_HI: d.rdata = {4'h0, q.err[11:8]};
				A_TRK_LO: d.rdata = q.trk[7:0];
				A_TRK_HI: d.rdata = {6'h00, q.trk[9:8]};
				A_SECT:   d.rdata = q.sect;
				default:  d.rdata = '0;
			endcase
		end

		// host commands
		if (wr_i) begin
			unique case (addr_i)
				A_CYL_HI: begin
					if (cmd_ok) begin
						d.trk[9:8] = wdata_i[1:0]; // [RULE2]
					end
				end
				A_SEEK: begin
					if (cmd_ok) begin
						d.trk[7:0] = wdata_i; // [RULE3]
						d.busy = 1'b1; // [RULE4]
						d.st = S_SEEK;
						d.seek_req = 1'b1;
					end
				end
				A_RECAL: begin
					d.err = '0; // [RULE6]
					d.trk = '0; // [RULE7]
					d.busy = 1'b1;
					d.st = S_RECAL;
					d.seek_req = 1'b1;
					d.recal = 1'b1;
					d.ptr_clr = q.xact;
					d.xact = 1'b0;
				end
				A_READ, A_WRITE, A_CHECK: begin
					if (cmd_ok) begin
						d.sect = wdata_i; // [RULE9] [RULE15]
						d.err.overrun = 1'b0;
						d.err.crc = 1'b0;
						if (addr_i != A_READ) begin
							d.err.protect = drv_i.protect;
						end
						if (wdata_i > SECT_MAX) begin
							d.err.missing = 1'b1; // [RULE23]
						end else if (addr_i != A_READ && drv_i.protect) begin
							d.err.protect = 1'b1; // [RULE20]
						end else begin
							d.xact = 1'b1; // [RULE10]
							d.xfer_req = 1'b1;
							unique case (addr_i)
								A_READ: begin
									d.st = S_READ;
									d.mode = XM_READ;
								end
								A_WRITE: begin
									d.st = S_WRITE;
									d.mode = XM_WRITE;
								end
								default: begin
									d.st = S_WR_CHK;
									d.mode = XM_WRITE;
								end
							endcase
						end
					end
				end
				A_ERRRST: begin
					d.err.protect = 1'b0; // [RULE18]
					d.err.xfer_tmo = 1'b0;
					d.err.overrun = 1'b0;
					d.err.crc = 1'b0;
					d.err.missing = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// hardware sets win over software clears
		d.err = d.err | ev;
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign seek_req_o = q.seek_req;
	assign recal_o = q.recal;
	assign seek_track_o = q.trk;
	assign xfer_req_o = q.xfer_req;
	assign xfer_mode_o = q.mode;
	assign xfer_sector_o = q.sect;
	assign buf_ptr_clr_o = q.ptr_clr;
	assign busy_o = q.busy;
	assign xfer_active_o = q.xact;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n);

	a_cyl_high_load: assert property ( // [RULE2]
		wr_i && addr_i == A_CYL_HI && cmd_ok |=> seek_track_o[9:8] == $past(wdata_i[1:0]))
		else $error("track high bits not loaded");

	a_seek_start: assert property ( // [RULE3]
		wr_i && addr_i == A_SEEK && cmd_ok
		|=> seek_req_o && busy_o && seek_track_o[7:0] == $past(wdata_i))
		else $error("seek not started with loaded track");

	a_seek_err_drop: assert property ( // [RULE4]
		in_seek && seek_i.err && !wr_i |=> !busy_o && q.err.pos_err)
		else $error("busy held after seek error");

	a_recal_clear: assert property ( // [RULE6]
		wr_i && addr_i == A_RECAL && ev == '0 |=> q.err == '0)
		else $error("recalibrate left a flag set");

	a_recal_home: assert property ( // [RULE7]
		wr_i && addr_i == A_RECAL |=> recal_o && seek_req_o && seek_track_o == '0)
		else $error("recalibrate not sent to track zero");

	a_read_start: assert property ( // [RULE10]
		wr_i && addr_i == A_READ && cmd_ok && wdata_i <= SECT_MAX
		|=> xfer_active_o && xfer_req_o && xfer_mode_o == XM_READ ##1 !xfer_req_o)
		else $error("read transfer not started");

	a_miss_flag: assert property ( // [RULE11]
		in_xfer && xfer_i.miss && !xfer_tmo && !wr_i |=> !xfer_active_o && q.err.missing)
		else $error("missing sector not flagged");

	a_overrun_flag: assert property ( // [RULE12]
		in_xfer && xfer_i.overrun && !xfer_tmo && !xfer_i.miss && !wr_i
		|=> !xfer_active_o && q.err.overrun && q.err.xfer_fail)
		else $error("overrun not flagged");

	a_xfer_tmo_flag: assert property ( // [RULE14]
		in_xfer && xfer_tmo && !wr_i |=> !xfer_active_o && q.err.xfer_tmo && q.err.xfer_fail)
		else $error("transfer timeout not flagged");

	a_verify_pass: assert property ( // [RULE16]
		q.st == S_WR_CHK && xfer_i.done && !xfer_i.miss && !xfer_i.overrun && !xfer_tmo
		&& !wr_i |=> xfer_req_o && xfer_mode_o == XM_CHECK && xfer_active_o)
		else $error("verify pass not started");

	a_ptr_clear: assert property ( // [RULE19]
		$fell(xfer_active_o) |-> buf_ptr_clr_o)
		else $error("buffer pointer not cleared");

	a_err_reset: assert property ( // [RULE18]
		wr_i && addr_i == A_ERRRST && ev == '0
		|=> !q.err.protect && !q.err.crc && !q.err.missing
		&& !q.err.xfer_tmo && !q.err.overrun
		&& q.err.pos_err == $past(q.err.pos_err) && q.err.fault == $past(q.err.fault))
		else $error("error reset touched wrong flags");

	a_bad_sector: assert property ( // [RULE23]
		wr_i && addr_i == A_READ && cmd_ok && wdata_i > SECT_MAX
		|=> q.err.missing && !xfer_active_o && !xfer_req_o)
		else $error("sector above range accepted");

	a_seek_tmo_flag: assert property ( // [RULE21]
		in_seek && seek_tmo && !wr_i |=> !busy_o && q.err.pos_tmo)
		else $error("seek timeout not flagged");

	a_crc_flag: assert property ( // [RULE13]
		in_xfer && xfer_i.crc && (q.st == S_READ || q.st == S_CHECK) && !xfer_tmo
		&& !xfer_i.miss && !xfer_i.overrun && !wr_i
		|=> !xfer_active_o && q.err.crc && q.err.xfer_fail)
		else $error("checksum failure not flagged");

	a_protect_flag: assert property ( // [RULE20]
		wr_i && addr_i == A_WRITE && cmd_ok && drv_i.protect
		|=> q.err.protect && !xfer_active_o && !xfer_req_o)
		else $error("write on protected media not refused");

	a_cmd_refused: assert property ( // [RULE1]
		wr_i && addr_i == A_READ && !cmd_ok && !in_xfer
		|=> !xfer_active_o && xfer_sector_o == $past(xfer_sector_o))
		else $error("refused sector command took effect");
endmodule

// File: bench/dcs_drive_model.sv
// behavioural drive mechanism answering seeks and sector passes after a delay
module dcs_drive_model import dcs_pkg::*; (
	// clock
	input  wire logic       mclk_i,
	// requests from the sequencer
	input  wire logic       seek_req_i,
	input  wire logic       xfer_req_i,
	input  wire xfer_mode_t mode_i,
	// behaviour chosen by the bench
	input  wire logic [7:0] dly_i,
	input  wire logic [2:0] fail_i,
	// answers, one-cycle pulses
	output seek_rsp_t       seek_o,
	output xfer_rsp_t       xfer_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int sc = 0;
	int xc = 0;
	// fail: 1 miss or seek error, 2 overrun, 3 crc, 4 no answer,
	// 5 miss and 6 crc on any pass but a write pass (done there)
	always @(posedge mclk_i) begin
		seek_o <= '0;
		xfer_o <= '0;
		if (seek_req_i) sc <= dly_i;
		else if (sc > 0) sc <= sc - 1;
		if (xfer_req_i) xc <= dly_i;
		else if (xc > 0) xc <= xc - 1;
		if (sc == 1 && fail_i != 3'd4) seek_o <= (fail_i == 3'd1) ? 2'b01 : 2'b10;
		if (xc == 1) begin
			if (fail_i == 3'd0 || (mode_i == XM_WRITE && fail_i > 3'd4)) xfer_o.done <= 1'b1;
			else if (fail_i == 3'd1 || fail_i == 3'd5) xfer_o.miss <= 1'b1;
			else if (fail_i == 3'd2) xfer_o.overrun <= 1'b1;
			else if (fail_i != 3'd4) xfer_o.crc <= 1'b1;
		end
	end
endmodule

// File: bench/disk_command_sequencer_bench.sv
// self-checking bench of the disk command sequencer
module disk_command_sequencer_bench import dcs_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] addr = '0;
	logic [7:0] wdata = '0;
	logic       wr_s = 1'b0;
	logic       rd_s = 1'b0;
	drv_stat_t  drv = 6'h20;
	logic [7:0] dly = 8'd9;
	logic [2:0] fail = '0;
	logic [2:0] modes = '0;
	logic [7:0] rdata, sector;
	logic [9:0] track;
	logic       seek_req, recal, xfer_req, ptr_clr, busy, xact;
	xfer_mode_t mode;
	seek_rsp_t  seek_rsp;
	xfer_rsp_t  xfer_rsp;
	int         num_errors = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         n_clr = 0;
	int         n_recal = 0;

	always #2 mclk = ~mclk;

	disk_command_sequencer #(.SEEK_TMO_CYC(64), .XFER_TMO_CYC(64)) i_dut (
		.mclk_i(mclk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .drv_i(drv), .seek_i(seek_rsp),
		.xfer_i(xfer_rsp), .seek_req_o(seek_req), .recal_o(recal), .seek_track_o(track),
		.xfer_req_o(xfer_req), .xfer_mode_o(mode), .xfer_sector_o(sector),
		.buf_ptr_clr_o(ptr_clr), .busy_o(busy), .xfer_active_o(xact)
	);

	dcs_drive_model i_drive (
		.mclk_i(mclk), .seek_req_i(seek_req), .xfer_req_i(xfer_req), .mode_i(mode),
		.dly_i(dly), .fail_i(fail), .seek_o(seek_rsp), .xfer_o(xfer_rsp)
	);

	// pulse counters, sampled mid-cycle
	always @(negedge mclk) begin
		if (ptr_clr === 1'b1) n_clr++;
		if (recal === 1'b1 && seek_req === 1'b1) n_recal++;
		if (xfer_req === 1'b1) modes = modes | 3'(1 << mode);
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk);
		wr_s <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk);
		rd_s <= 1'b0;
		@(negedge mclk);
		d = rdata;
		@(posedge mclk);
	endtask

	task automatic errs(input logic [11:0] exp);
		logic [7:0] lo, hi;
		rd(A_ERR_LO, lo);
		rd(A_ERR_HI, hi);
		chk("error flags", {hi[3:0], lo}, exp);
	endtask

	// waits for busy and transfer-active to clear; act says whether they rose
	task automatic idle(input logic act);
		int n;
		for (n = 0; n < 300; n++) begin
			@(negedge mclk);
			if (busy === 1'b0 && xact === 1'b0) break;
		end
		@(posedge mclk);
		chk("activity", 12'(n > 0 && n < 300), 12'(act));
	endtask

	task automatic restore();
		int c;
		c = n_recal;
		fail <= '0;
		wr(A_RECAL, 8'h00);
		idle(1'b1);
		chk("recal pulses", 12'(n_recal - c), 12'h001);
		chk("track", 12'(track), 12'h000);
		errs(12'h000);
	endtask

	task automatic xfer(input logic [3:0] cmd, input logic [7:0] s, input logic [2:0] f,
			input logic [11:0] exp, input logic [2:0] m);
		int c;
		logic [7:0] d;
		c = n_clr;
		modes = '0;
		fail <= f;
		wr(cmd, s);
		idle(|m);
		chk("modes", 12'(modes), 12'(m));
		if (m != 3'b000) begin
			rd(A_SECT, d);
			chk("sector", 12'(sector), 12'(s));
			chk("sector register", 12'(d), 12'(s));
		end
		if (f == 3'd0) chk("pointer clears", 12'(n_clr - c), 12'(|m));
		errs(exp);
		restore();
	endtask

	task automatic t_reset();
		logic [7:0] d;
		rd(A_STATUS, d);
		chk("status", 12'(d), 12'h004);
		@(negedge mclk);
		chk("read data after", 12'(rdata), 12'h000);
		@(posedge mclk);
		rd(4'hf, d);
		chk("unmapped", 12'(d), 12'h000);
		errs(12'h000);
	endtask

	task automatic t_seek();
		logic [7:0] d;
		dly <= 8'd2;
		wr(A_CYL_HI, 8'hfe);
		wr(A_SEEK, 8'h5a);
		idle(1'b1);
		chk("track", 12'(track), 12'h25a);
		rd(A_TRK_HI, d);
		chk("track high", 12'(d), 12'h002);
		rd(A_TRK_LO, d);
		chk("track low", 12'(d), 12'h05a);
		errs(12'h000);
		dly <= 8'd9;
	endtask

	task automatic t_seek_err();
		fail <= 3'd1;
		wr(A_SEEK, 8'h11);
		idle(1'b1);
		errs(12'h001);
		xfer(A_READ, 8'h01, 3'd0, 12'h001, 3'b000);
		fail <= 3'd4;
		wr(A_SEEK, 8'h22);
		idle(1'b1);
		errs(12'h100);
		restore();
	endtask

	task automatic t_xfer();
		xfer(A_READ, 8'h2f, 3'd0, 12'h000, 3'b001);
		xfer(A_WRITE, 8'h00, 3'd0, 12'h000, 3'b010);
		xfer(A_CHECK, 8'h07, 3'd0, 12'h000, 3'b110);
		xfer(A_READ, 8'h03, 3'd1, 12'h200, 3'b001);
		xfer(A_WRITE, 8'h03, 3'd1, 12'h200, 3'b010);
		xfer(A_CHECK, 8'h03, 3'd1, 12'h200, 3'b010);
		xfer(A_CHECK, 8'h03, 3'd5, 12'h200, 3'b110);
		xfer(A_READ, 8'h04, 3'd2, 12'h012, 3'b001);
		xfer(A_WRITE, 8'h04, 3'd2, 12'h012, 3'b010);
		xfer(A_CHECK, 8'h04, 3'd2, 12'h012, 3'b010);
		xfer(A_READ, 8'h05, 3'd3, 12'h022, 3'b001);
		xfer(A_WRITE, 8'h05, 3'd3, 12'h00a, 3'b010);
		xfer(A_CHECK, 8'h05, 3'd6, 12'h022, 3'b110);
		xfer(A_READ, 8'h06, 3'd4, 12'h00a, 3'b001);
		xfer(A_WRITE, 8'h06, 3'd4, 12'h00a, 3'b010);
		xfer(A_CHECK, 8'h06, 3'd4, 12'h00a, 3'b010);
		xfer(A_READ, 8'h30, 3'd0, 12'h200, 3'b000);
	endtask

	task automatic t_flags();
		logic [7:0] d;
		drv <= 6'h3f;
		@(posedge mclk);
		drv <= 6'h30;
		wr(A_WRITE, 8'h01);
		idle(1'b0);
		errs(12'hcc4);
		wr(A_ERRRST, 8'h00);
		errs(12'hcc0);
		drv <= 6'h00;
		wr(A_READ, 8'h02);
		idle(1'b0);
		chk("sector", 12'(sector), 12'h001);
		rd(A_STATUS, d);
		chk("status", 12'(d), 12'h000);
		drv <= 6'h20;
		restore();
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		t_reset();
		t_seek();
		t_seek_err();
		t_xfer();
		t_flags();
		final_report();
	end
endmodule
